/* File: hdl/rts_pkg.sv */
// ****************************************************************
// reset sequencer constants
// ****************************************************************
package rts_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned POWER_UP_DELAY_TIME_MS = 72;
    localparam int unsigned RC_TICK_PERIOD_NS = 1000; // internal rc tick period
    localparam int unsigned POWER_UP_DELAY_TICKS =
        (POWER_UP_DELAY_TIME_MS * 1000000 + RC_TICK_PERIOD_NS - 1) / RC_TICK_PERIOD_NS;
    localparam int unsigned DROOP_MIN_DURATION_US = 100;
    localparam int unsigned DROOP_MIN_CYCLES =
        (DROOP_MIN_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OSC_SETTLE_CYCLES = 1024;
    localparam int unsigned CLEAR_FILTER_CYCLES = 4;
    localparam int unsigned RESET_PULSE_CYCLES = 2;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] CFG_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] SCRATCH_OFFSET = 12'h008;

    // config fields
    localparam int unsigned CFG_DELAY_EN_BIT = 0;
    localparam int unsigned CFG_DROOP_EN_BIT = 1;
    localparam int unsigned CFG_OSC_LSB = 2;
    localparam logic CFG_DELAY_EN_RESET = 1'b0;
    localparam logic CFG_DROOP_EN_RESET = 1'b1;

    // status fields
    localparam int unsigned ST_TIMEOUT_BIT = 0;
    localparam int unsigned ST_POWERDOWN_BIT = 1;
    localparam int unsigned ST_POWER_ON_BIT = 2;
    localparam int unsigned ST_DROOP_BIT = 3;
    localparam int unsigned ST_DROOP_VALID_BIT = 4;
    localparam int unsigned ST_CAUSE_LSB = 5;
    localparam int unsigned ST_STATE_LSB = 8;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        OSC_LOW_POWER_CRYSTAL = 2'b00,
        OSC_CRYSTAL = 2'b01,
        OSC_HIGH_SPEED_CRYSTAL = 2'b10,
        OSC_RESISTOR_CAPACITOR = 2'b11
    } rts_osc_e;

    localparam rts_osc_e CFG_OSC_RESET = OSC_RESISTOR_CAPACITOR;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_POWER_ON = 3'h1,
        CAUSE_CLEAR_RUN = 3'h2,
        CAUSE_CLEAR_SLEEP = 3'h3,
        CAUSE_WDT_RESET = 3'h4,
        CAUSE_WDT_WAKE = 3'h5,
        CAUSE_DROOP = 3'h6
    } rts_cause_e;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_DELAY = 3'b001,
        ST_SETTLE = 3'b011,
        ST_RUN = 3'b010,
        ST_HOLD = 3'b110,
        ST_PULSE = 3'b111,
        ST_DROOP = 3'b101,
        ST_WAKE = 3'b100
    } rts_state_e;

endpackage

/* File: hdl/rts_pin_filter.sv */
`timescale 1ns/1ps
// ****************************************************************
// clear pin synchroniser and glitch filter
// ****************************************************************
module rts_pin_filter #(
    parameter int unsigned FILTER_CYCLES = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin
    input wire logic pin_raw,
    output logic pin_clean
);
    localparam int unsigned CW = $clog2(FILTER_CYCLES + 1);

    if (FILTER_CYCLES < 1) begin : g_chk
        $error("rts_pin_filter: FILTER_CYCLES must be at least 1");
    end

    logic sync_a;
    logic sync_b;
    logic [CW-1:0] stable_cnt;

    // two flop synchroniser, released level at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else begin
            sync_a <= pin_raw;
            sync_b <= sync_a;
        end
    end

    // new level must persist before it is passed on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_cnt <= '0;
            pin_clean <= 1'b1;
        end else if (sync_b == pin_clean) begin
            stable_cnt <= '0;
        end else if (stable_cnt == CW'(FILTER_CYCLES - 1)) begin
            stable_cnt <= '0;
            pin_clean <= sync_b;
        end else begin
            stable_cnt <= stable_cnt + 1'b1;
        end
    end
endmodule

/* File: hdl/rts_tick_timer.sv */
`timescale 1ns/1ps
// ****************************************************************
// one shot tick counter
// ****************************************************************
module rts_tick_timer #(
    parameter int unsigned WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    input wire logic tick,
    input wire logic [WIDTH-1:0] limit,
    // status
    output logic done
);
    if (WIDTH < 1) begin : g_chk
        $error("rts_tick_timer: WIDTH must be at least 1");
    end

    logic active;
    logic [WIDTH-1:0] count;
    wire last_tick = (count == limit - 1'b1);

    // restart on start, count ticks, stop at limit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
            done <= 1'b0;
            count <= '0;
        end else if (start) begin
            active <= 1'b1;
            done <= 1'b0;
            count <= '0;
        end else if (active && tick) begin
            if (last_tick) begin
                active <= 1'b0;
                done <= 1'b1;
            end else begin
                count <= count + 1'b1;
            end
        end
    end
endmodule

/* File: hdl/rts_reset_sequencer.sv */
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
// ****************************************************************
// reset cause and time-out sequencer
// ****************************************************************
module rts_reset_sequencer
    import rts_pkg::*;
#(
    parameter int unsigned POWER_UP_DELAY_TICKS_P = POWER_UP_DELAY_TICKS,
    parameter int unsigned DROOP_MIN_CYCLES_P = DROOP_MIN_CYCLES,
    parameter int unsigned SETTLE_CYCLES_P = OSC_SETTLE_CYCLES,
    parameter int unsigned CLEAR_FILTER_CYCLES_P = CLEAR_FILTER_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset sources
    input wire logic external_clear_pin_n,
    input wire logic power_on_event,
    input wire logic supply_below_threshold,
    input wire logic watchdog_expire,
    // core status and clock ticks
    input wire logic clear_watchdog,
    input wire logic sleep_state,
    input wire logic rc_tick,
    input wire logic clock_input_tick,
    // core control
    output logic core_reset_n,
    output logic core_stall,
    output logic wake_resume,
    output rts_cause_e reset_cause
);
    localparam int unsigned DLY_W = $clog2(POWER_UP_DELAY_TICKS_P + 1);
    localparam int unsigned DRP_W = $clog2(DROOP_MIN_CYCLES_P + 1);
    localparam int unsigned SET_W = $clog2(SETTLE_CYCLES_P + 1);
    localparam int unsigned PUL_W = $clog2(RESET_PULSE_CYCLES + 1);
    if (POWER_UP_DELAY_TICKS_P < 1 || DROOP_MIN_CYCLES_P < 1 ||
        SETTLE_CYCLES_P < 1) begin : g_chk
        $error("rts_reset_sequencer: counts must be at least 1");
    end
    // ****************************************************************
    // state
    // ****************************************************************
    rts_state_e state, next_state;
    rts_cause_e next_cause;
    rts_osc_e cfg_osc;
    logic cause_load, next_wake, cfg_delay_en, cfg_droop_en, clear_level, sleep_prev;
    logic timeout_flag, powerdown_flag, power_on_flag, droop_flag;
    logic delay_done, settle_done, droop_long;
    logic [31:0] scratch;
    logic [PUL_W-1:0] pulse_cnt;
    // ****************************************************************
    // clear pin path and timers
    // ****************************************************************
    // the clear pin is only an input here; no reset drives it
    rts_pin_filter #(.FILTER_CYCLES(CLEAR_FILTER_CYCLES_P)) u_clear_filter (
        .clk(pclk),
        .rst_n(presetn),
        .pin_raw(external_clear_pin_n),
        .pin_clean(clear_level)
    );
    // entries into timed states
    wire delay_start = (next_state == ST_DELAY) && (state != ST_DELAY);
    wire settle_enter = (next_state == ST_SETTLE) || (next_state == ST_WAKE);
    wire settle_start = settle_enter && (state != next_state);
    // power-up delay on the internal rc tick
    rts_tick_timer #(.WIDTH(DLY_W)) u_delay_timer (
        .clk(pclk),
        .rst_n(presetn),
        .start(delay_start),
        .tick(rc_tick),
        .limit(DLY_W'(POWER_UP_DELAY_TICKS_P)),
        .done(delay_done)
    );
    // oscillator settle on clock input ticks
    rts_tick_timer #(.WIDTH(SET_W)) u_settle_timer (
        .clk(pclk),
        .rst_n(presetn),
        .start(settle_start),
        .tick(clock_input_tick),
        .limit(SET_W'(SETTLE_CYCLES_P)),
        .done(settle_done)
    );
    // droop duration, restarted while supply is good
    rts_tick_timer #(.WIDTH(DRP_W)) u_droop_timer (
        .clk(pclk),
        .rst_n(presetn),
        .start(!supply_below_threshold),
        .tick(1'b1),
        .limit(DRP_W'(DROOP_MIN_CYCLES_P)),
        .done(droop_long)
    );
    // ****************************************************************
    // event decode
    // ****************************************************************
    wire crystal = (cfg_osc != OSC_RESISTOR_CAPACITOR);
    wire delay_on = cfg_delay_en || cfg_droop_en;
    wire droop_hit = cfg_droop_en && droop_long && supply_below_threshold;
    wire clear_ok = clear_level;
    wire pulse_done = (pulse_cnt == PUL_W'(RESET_PULSE_CYCLES - 1));
    wire sleep_enter = sleep_state && !sleep_prev;
    wire droop_cause = (reset_cause == CAUSE_DROOP);
    // release into run, or hold while the clear pin stays low
    wire rts_state_e run_or_hold = clear_ok ? ST_RUN : ST_HOLD;
    // after the delay, settle only for crystal power-on
    wire rts_state_e after_delay = (crystal && !droop_cause) ? ST_SETTLE : run_or_hold;
    // ****************************************************************
    // sequencer next state
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_cause = reset_cause;
        cause_load = 1'b0;
        next_wake = 1'b0;
        case (state)
            ST_DELAY: begin
                if (droop_cause && cfg_droop_en && supply_below_threshold) begin
                    next_state = ST_DROOP;
                end else if (delay_done) begin
                    next_state = after_delay;
                end
            end
            ST_SETTLE: begin
                if (settle_done) begin
                    next_state = run_or_hold;
                end
            end
            ST_RUN: begin
                if (!clear_ok) begin
                    next_state = ST_HOLD;
                    cause_load = 1'b1;
                    next_cause = sleep_state ? CAUSE_CLEAR_SLEEP : CAUSE_CLEAR_RUN;
                end else if (watchdog_expire && sleep_state) begin
                    cause_load = 1'b1;
                    next_cause = CAUSE_WDT_WAKE;
                    if (crystal) begin
                        next_state = ST_WAKE;
                    end else begin
                        next_wake = 1'b1;
                    end
                end else if (watchdog_expire) begin
                    next_state = ST_PULSE;
                    cause_load = 1'b1;
                    next_cause = CAUSE_WDT_RESET;
                end
            end
            ST_HOLD: begin
                if (clear_ok) begin
                    next_state = ST_RUN;
                end
            end
            ST_PULSE: begin
                if (pulse_done) begin
                    next_state = run_or_hold;
                end
            end
            ST_DROOP: begin
                if (!supply_below_threshold) begin
                    next_state = ST_DELAY;
                end
            end
            ST_WAKE: begin
                if (!clear_ok) begin
                    next_state = ST_HOLD;
                    cause_load = 1'b1;
                    next_cause = CAUSE_CLEAR_SLEEP;
                end else if (settle_done) begin
                    next_state = ST_RUN;
                    next_wake = 1'b1;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        // power-on wins over everything, then droop
        if (power_on_event) begin
            cause_load = 1'b1;
            next_cause = CAUSE_POWER_ON;
            next_wake = 1'b0;
            if (delay_on) begin
                next_state = ST_DELAY;
            end else if (crystal) begin
                next_state = ST_SETTLE;
            end else begin
                next_state = run_or_hold;
            end
        end else if (droop_hit && state != ST_DROOP) begin
            next_state = ST_DROOP;
            cause_load = 1'b1;
            next_cause = CAUSE_DROOP;
            next_wake = 1'b0;
        end
    end
    // state and registered core controls, released on the clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_OFF;
            reset_cause <= CAUSE_NONE;
            core_reset_n <= 1'b0;
            core_stall <= 1'b0;
            wake_resume <= 1'b0;
            sleep_prev <= 1'b0;
        end else begin
            state <= next_state;
            reset_cause <= next_cause;
            core_reset_n <= (next_state == ST_RUN) || (next_state == ST_WAKE);
            core_stall <= (next_state == ST_WAKE);
            wake_resume <= next_wake;
            sleep_prev <= sleep_state;
        end
    end
    // watchdog reset pulse length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt <= '0;
        end else if (state != ST_PULSE) begin
            pulse_cnt <= '0;
        end else begin
            pulse_cnt <= pulse_cnt + 1'b1;
        end
    end

    // ****************************************************************
    // apb decode
    // ****************************************************************
    wire sel_cfg = (paddr == CFG_OFFSET);
    wire sel_status = (paddr == STATUS_OFFSET);
    wire sel_scratch = (paddr == SCRATCH_OFFSET);
    wire addr_hit = sel_cfg || sel_status || sel_scratch;
    wire access = psel && penable && !pready;
    wire wr_fire = psel && penable && pready && pwrite;
    wire wr_cfg = wr_fire && sel_cfg;
    wire wr_status = wr_fire && sel_status;
    wire wr_scratch = wr_fire && sel_scratch;

    // read words
    wire [31:0] cfg_word = {28'h000_0000, cfg_osc, cfg_droop_en, cfg_delay_en};
    wire [31:0] status_word = {21'h00_0000, state, reset_cause, cfg_droop_en,
        droop_flag, power_on_flag, powerdown_flag, timeout_flag};
    wire [31:0] rd_mux = sel_cfg ? cfg_word :
        sel_status ? status_word :
        sel_scratch ? scratch : 32'h0000_0000;

    // one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && !addr_hit;
            prdata <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // configuration
    // ****************************************************************
    // configuration survives every reset but the block reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_delay_en <= CFG_DELAY_EN_RESET;
            cfg_droop_en <= CFG_DROOP_EN_RESET;
            cfg_osc <= CFG_OSC_RESET;
        end else if (wr_cfg) begin
            cfg_delay_en <= pwdata[CFG_DELAY_EN_BIT];
            cfg_droop_en <= pwdata[CFG_DROOP_EN_BIT];
            cfg_osc <= rts_osc_e'(pwdata[CFG_OSC_LSB +: 2]);
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    // timeout and powerdown per cause, then core events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (cause_load) begin
            case (next_cause)
                CAUSE_POWER_ON, CAUSE_DROOP: begin
                    timeout_flag <= 1'b1;
                    powerdown_flag <= 1'b1;
                end
                CAUSE_WDT_RESET: begin
                    timeout_flag <= 1'b0;
                    powerdown_flag <= 1'b1;
                end
                CAUSE_WDT_WAKE: begin
                    timeout_flag <= 1'b0;
                    powerdown_flag <= 1'b0;
                end
                CAUSE_CLEAR_SLEEP: begin
                    timeout_flag <= 1'b1;
                    powerdown_flag <= 1'b0;
                end
                default: begin
                end
            endcase
        end else if (clear_watchdog) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (sleep_enter) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
        end
    end
    // power-on flag: cleared by power-on, set by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_on_flag <= 1'b0;
        end else if (cause_load && next_cause == CAUSE_POWER_ON) begin
            power_on_flag <= 1'b0;
        end else if (wr_status && pwdata[ST_POWER_ON_BIT]) begin
            power_on_flag <= 1'b1;
        end
    end
    // droop flag: no reset, cleared by droop, set by software
    always_ff @(posedge pclk) begin
        if (cause_load && next_cause == CAUSE_DROOP) begin
            droop_flag <= 1'b0;
        end else if (wr_status && pwdata[ST_DROOP_BIT]) begin
            droop_flag <= 1'b1;
        end
    end
    // scratch word untouched by any reset
    always_ff @(posedge pclk) begin
        if (wr_scratch) begin
            scratch <= pwdata;
        end
    end
endmodule

/* File: dv/rts_partner.sv */
`timescale 1ns/1ps
// ****************************************************************
// tick sources beside the sequencer
// ****************************************************************
module rts_partner #(
    parameter int unsigned RC_DIV = 4,
    parameter int unsigned CK_DIV = 2
) (
    // clock
    input wire logic pclk,
    // ticks
    output logic rc_tick,
    output logic clock_input_tick
);
    int rc_n = 0;
    int ck_n = 0;
    // free running dividers, rc ticks slower than clock input ticks
    always @(posedge pclk) begin
        rc_n <= (rc_n + 1) % RC_DIV;
        ck_n <= (ck_n + 1) % CK_DIV;
        rc_tick <= (rc_n == 0);
        clock_input_tick <= (ck_n == 0);
    end
endmodule

/* File: dv/rts_chk.sv */
`timescale 1ns/1ps
// ****************************************************************
// port checker of the reset sequencer
// ****************************************************************
module rts_chk
    import rts_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // sources and core control
    input wire logic external_clear_pin_n,
    input wire logic power_on_event,
    input wire logic supply_below_threshold,
    input wire logic watchdog_expire,
    input wire logic sleep_state,
    input wire logic core_reset_n,
    input wire logic core_stall,
    input wire logic wake_resume,
    input wire rts_cause_e reset_cause
);
    logic mapped;
    logic quiet;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // address decode and running core without other causes
    assign mapped = paddr == CFG_OFFSET || paddr == STATUS_OFFSET || paddr == SCRATCH_OFFSET;
    assign quiet = core_reset_n && !core_stall && !power_on_event &&
        !supply_below_threshold && external_clear_pin_n;
    a_boot_held: assert property (
        $rose(presetn) |-> !core_reset_n && reset_cause == CAUSE_NONE)
        else $error("core left reset without power-on");
    a_por_cause: assert property (
        power_on_event |=> reset_cause == CAUSE_POWER_ON)
        else $error("power-on cause not recorded");
    a_wdt_reset: assert property (
        watchdog_expire && !sleep_state && quiet |=>
        (reset_cause == CAUSE_WDT_RESET && !core_reset_n)[*2] ##[1:3] core_reset_n)
        else $error("watchdog reset pulse wrong");
    a_wdt_wake: assert property (
        watchdog_expire && sleep_state && quiet |=>
        reset_cause == CAUSE_WDT_WAKE && core_reset_n)
        else $error("watchdog wake reset the core");
    a_wake_pulse: assert property (
        wake_resume |-> core_reset_n ##1 !wake_resume)
        else $error("wake resume not a single pulse");
    a_stall_alive: assert property (
        core_stall |-> core_reset_n)
        else $error("stall while core in reset");
    a_clear_hold: assert property (
        !external_clear_pin_n [*8] |=> !core_reset_n)
        else $error("clear pin low did not hold reset");
    a_droop_hold: assert property (
        supply_below_threshold [*8] |=> !core_reset_n)
        else $error("long droop did not reset");
    a_droop_delay: assert property (
        supply_below_threshold [*6] ##1 !supply_below_threshold |-> !core_reset_n [*8])
        else $error("released without delay after droop");
    a_err_map: assert property (
        pready |-> pslverr == !mapped)
        else $error("slave error does not match decode");
    // main scenarios reached
    c_wake: cover property (wake_resume);
    c_stall: cover property (core_stall);
    c_err: cover property (pready && pslverr);
endmodule

bind rts_reset_sequencer rts_chk u_chk (.pclk, .presetn, .paddr, .pready, .pslverr,
    .external_clear_pin_n, .power_on_event, .supply_below_threshold, .watchdog_expire,
    .sleep_state, .core_reset_n, .core_stall, .wake_resume, .reset_cause);

/* File: dv/tb.sv */
`timescale 1ns/1ps
// ****************************************************************
// reset sequencer testbench
// ****************************************************************
module tb;
    import rts_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, val;
    logic pready, pslverr, rc_tick, clock_input_tick, core_reset_n, core_stall, wake_resume;
    logic external_clear_pin_n = 1, power_on_event = 0, supply_below_threshold = 0;
    logic watchdog_expire = 0, sleep_state = 0;
    logic [3:0] cfg;
    rts_cause_e reset_cause;
    int seed = 42, failures = 0, n_compared = 0, n;
    rts_reset_sequencer #(.POWER_UP_DELAY_TICKS_P(8), .DROOP_MIN_CYCLES_P(5),
        .SETTLE_CYCLES_P(16)) u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .external_clear_pin_n, .power_on_event,
        .supply_below_threshold, .watchdog_expire, .clear_watchdog(1'h0), .sleep_state,
        .rc_tick, .clock_input_tick, .core_reset_n, .core_stall, .wake_resume, .reset_cause);
    rts_partner u_far (.pclk, .rc_tick, .clock_input_tick);
    // 100 MHz clock
    initial forever #5 pclk = ~pclk;
    task report_and_stop;
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, waits for pready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (k >= 20) begin
            failures++;
            report_and_stop();
        end
    endtask
    // cycles until the core leaves reset
    task wait_rel;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (core_reset_n !== 1'h1 && n < 3000);
        if (n >= 3000) begin
            failures++;
            report_and_stop();
        end
    endtask
    // delay (4 cycles a tick) when enabled or forced, settle (2 a tick) in crystal modes
    function int exp_rel(input logic [3:0] c);
        return ((c[0] | c[1]) ? 32 : 0) + ((c[3:2] != 2'h3) ? 32 : 0);
    endfunction
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_000e);
        apb(0, 12'h00c, 32'h0000_0000);
        chk(err, 1'h1);
        chk(rd, 32'h0000_0000);
        val = $random(seed);
        apb(1, 12'h008, val);
        @(posedge pclk) presetn <= 0;
        @(posedge pclk) presetn <= 1;
        apb(0, 12'h008, 32'h0000_0000);
        chk(rd, val);
        for (int m = 0; m < 4; m++) begin
            cfg = {m[1:0], (m == 3) ? 2'h0 : 2'($random(seed))};
            apb(1, 12'h000, 32'(cfg));
            @(posedge pclk) power_on_event <= 1;
            @(posedge pclk) power_on_event <= 0;
            wait_rel();
            chk(n >= exp_rel(cfg) - 8 && n <= exp_rel(cfg) + 16, 1'h1);
            chk(reset_cause, CAUSE_POWER_ON);
            apb(0, 12'h004, 32'h0000_0000);
            chk(rd[2:0], 3'h3);
        end
        apb(1, 12'h000, 32'h0000_000e);
        apb(1, 12'h004, 32'h0000_0004);
        @(posedge pclk) watchdog_expire <= 1;
        @(posedge pclk) watchdog_expire <= 0;
        @(posedge pclk);
        chk(core_reset_n, 1'h0);
        wait_rel();
        chk(reset_cause, CAUSE_WDT_RESET);
        apb(0, 12'h004, 32'h0000_0000);
        chk(rd[2:0], 3'h6);
        apb(1, 12'h000, 32'h0000_0006);
        @(posedge pclk) sleep_state <= 1;
        @(posedge pclk) watchdog_expire <= 1;
        @(posedge pclk) watchdog_expire <= 0;
        @(posedge pclk) chk(core_stall, 1'h1);
        n = 0;
        while (wake_resume !== 1'h1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk(n >= 30 && n < 200, 1'h1);
        chk(reset_cause, CAUSE_WDT_WAKE);
        sleep_state <= 0;
        apb(0, 12'h004, 32'h0000_0000);
        chk(rd[1:0], 2'h0);
        @(posedge pclk) external_clear_pin_n <= 0;
        repeat (2) @(posedge pclk);
        external_clear_pin_n <= 1;
        repeat (12) @(posedge pclk);
        chk(core_reset_n, 1'h1);
        external_clear_pin_n <= 0;
        power_on_event <= 1;
        @(posedge pclk) power_on_event <= 0;
        repeat (200) @(posedge pclk);
        chk(core_reset_n, 1'h0);
        external_clear_pin_n <= 1;
        wait_rel();
        chk(n <= 10, 1'h1);
        @(posedge pclk) supply_below_threshold <= 1;
        repeat (20) @(posedge pclk);
        chk(core_reset_n, 1'h0);
        supply_below_threshold <= 0;
        wait_rel();
        chk(n >= 28, 1'h1);
        chk(reset_cause, CAUSE_DROOP);
        apb(0, 12'h004, 32'h0000_0000);
        chk(rd[3:0], 4'h3);
        report_and_stop();
    end
endmodule
